/* File: verilog/aeqc_pkg.sv */
// Constants, types and register map of the adaptive equalizer controller.
package aeqc_pkg;

    // Register indices and their word byte addresses on the bus.
    localparam logic [7:0]  CTL_INDEX    = 8'h42;
    localparam logic [7:0]  LIMIT_INDEX  = 8'h43;
    localparam logic [7:0]  STATUS_INDEX = 8'h44;
    localparam int          ADDR_W       = 12;
    localparam logic [11:0] CTL_ADDR     = {2'h0, CTL_INDEX, 2'h0};
    localparam logic [11:0] LIMIT_ADDR   = {2'h0, LIMIT_INDEX, 2'h0};
    localparam logic [11:0] STATUS_ADDR  = {2'h0, STATUS_INDEX, 2'h0};

    // Reset values.
    localparam logic [7:0]  CTL_RESET    = 8'h01;
    localparam logic [7:0]  LIMIT_RESET  = 8'h01;

    // Datapath widths and top setting values.
    localparam int          PERIOD_W     = 16;
    localparam int          EQ_W         = 4;
    localparam int          FILT_W       = 3;
    localparam int          CNT_W        = 9;
    localparam logic [EQ_W-1:0]   EQ_MAX   = 4'hf;
    localparam logic [FILT_W-1:0] FILT_MAX = 3'h7;

    // Status word field positions.
    localparam int          ST_EQ_LSB    = 0;
    localparam int          ST_FILT_LSB  = 4;
    localparam int          ST_STATE_LSB = 8;
    localparam int          ST_LOCK_BIT  = 10;
    localparam int          ST_CNT_LSB   = 16;

    // Bus transfer type bit that marks an active transfer.
    localparam int          HTRANS_ACT   = 1;

    // Control register layout, bit 7 reserved and reads as zero.
    typedef struct packed {
        logic [2:0] errSel;
        logic       spare;
        logic       twoStep;
        logic       loopOrder;
        logic       filtEn;
    } aeqc_ctrl_type;

    // Receiver error indications, in the same order as the select field.
    typedef struct packed {
        logic clkPattern;
        logic ctrlSeq;
        logic parity;
    } aeqc_err_type;

    // Adaptation states.
    typedef enum logic [1:0] {
        ST_TRY    = 2'b00,
        ST_VERIFY = 2'b01,
        ST_TRACK  = 2'b10
    } aeqc_state_type;

endpackage

/* File: verilog/aeqc_adaptive_eq_controller.sv */
// Adaptive equalizer controller with its AHB-Lite register slave.
`timescale 1ns/1ps
module aeqc_adaptive_eq_controller
(
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  wire logic                              hsel,
    input  wire logic [31:0]                       haddr,
    input  wire logic [1:0]                        htrans,
    input  wire logic                              hwrite,
    input  wire logic [2:0]                        hsize,
    input  wire logic [31:0]                       hwdata,
    input  wire logic                              hready,
    output logic                                   hreadyout,
    output logic [31:0]                            hrdata,
    output logic                                   hresp,
    input  wire logic                              rxLock,
    input  wire aeqc_pkg::aeqc_err_type            rxErr,
    input  wire logic [aeqc_pkg::PERIOD_W-1:0]     relockPeriod,
    output logic [aeqc_pkg::EQ_W-1:0]              eqSetting,
    output logic [aeqc_pkg::FILT_W-1:0]            filterSetting,
    output logic                                   adaptLocked
);

    // Steps the setting pair to the next candidate; with the filter enabled the inner loop carries into the outer, else only the equalizer steps.
    function automatic logic [aeqc_pkg::EQ_W+aeqc_pkg::FILT_W-1:0] nextSetting
    (
        input logic [aeqc_pkg::EQ_W-1:0]   eq,
        input logic [aeqc_pkg::FILT_W-1:0] filt,
        input logic                        filtEn,
        input logic                        order
    );
        logic [aeqc_pkg::EQ_W-1:0]   eqN;
        logic [aeqc_pkg::FILT_W-1:0] filtN;
        eqN   = eq;
        filtN = filt;
        if (!filtEn)
        begin
            eqN = eq + 1'b1;
        end
        else if (!order)
        begin
            eqN = eq + 1'b1;
            if (eq == aeqc_pkg::EQ_MAX)
            begin
                filtN = filt + 1'b1;
            end
        end
        else
        begin
            filtN = filt + 1'b1;
            if (filt == aeqc_pkg::FILT_MAX)
            begin
                eqN = eq + 1'b1;
            end
        end
        return {eqN, filtN};
    endfunction

    // Turns a period into a timer terminal value, never below one cycle.
    function automatic logic [aeqc_pkg::PERIOD_W-1:0] termOf
    (
        input logic [aeqc_pkg::PERIOD_W-1:0] period
    );
        logic [aeqc_pkg::PERIOD_W-1:0] t;
        t = (period == '0) ? 16'h0001 : period;
        return t - 1'b1;
    endfunction

    logic                               lockS1_q;
    logic                               lockS2_q;
    aeqc_pkg::aeqc_err_type             errS1_q;
    aeqc_pkg::aeqc_err_type             errS2_q;
    aeqc_pkg::aeqc_ctrl_type            ctrl_q;
    logic [7:0]                         limit_q;
    logic                               wrPend_q;
    logic [aeqc_pkg::ADDR_W-1:0]        wrAddr_q;
    aeqc_pkg::aeqc_state_type           state_q;
    aeqc_pkg::aeqc_state_type           state_d;
    logic [aeqc_pkg::PERIOD_W-1:0]      timer_q;
    logic [aeqc_pkg::PERIOD_W-1:0]      timer_d;
    logic [aeqc_pkg::CNT_W-1:0]         errCnt_q;
    logic [aeqc_pkg::CNT_W-1:0]         errCnt_d;
    logic [aeqc_pkg::EQ_W-1:0]          eq_q;
    logic [aeqc_pkg::EQ_W-1:0]          eq_d;
    logic [aeqc_pkg::FILT_W-1:0]        filt_q;
    logic [aeqc_pkg::FILT_W-1:0]        filt_d;
    logic                               locked_q;
    logic                               locked_d;
    logic [31:0]                        rdData_q;

    // Receiver indications come from another domain and pass two flip-flops.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            lockS1_q <= 1'b0;
            lockS2_q <= 1'b0;
            errS1_q  <= '0;
            errS2_q  <= '0;
        end
        else
        begin
            lockS1_q <= rxLock;
            lockS2_q <= lockS1_q;
            errS1_q  <= rxErr;
            errS2_q  <= errS1_q;
        end
    end

    // Bus decode: the address phase is taken when selected, active and the bus is ready.
    wire                          addrPhase = hsel && htrans[aeqc_pkg::HTRANS_ACT] && hready;
    wire [aeqc_pkg::ADDR_W-1:0]   busAddr   = haddr[aeqc_pkg::ADDR_W-1:0];
    wire                          wrCtl     = wrPend_q && (wrAddr_q == aeqc_pkg::CTL_ADDR);
    wire                          wrLimit   = wrPend_q && (wrAddr_q == aeqc_pkg::LIMIT_ADDR);
    wire [31:0]                   statusWord =
        (32'(eq_q) << aeqc_pkg::ST_EQ_LSB) | (32'(filt_q) << aeqc_pkg::ST_FILT_LSB) |
        (32'(state_q) << aeqc_pkg::ST_STATE_LSB) | (32'(locked_q) << aeqc_pkg::ST_LOCK_BIT) |
        (32'(errCnt_q) << aeqc_pkg::ST_CNT_LSB);
    wire [31:0]                   readMux =
        (busAddr == aeqc_pkg::CTL_ADDR)    ? {24'h000000, 1'b0, ctrl_q} :
        (busAddr == aeqc_pkg::LIMIT_ADDR)  ? {24'h000000, limit_q} :
        (busAddr == aeqc_pkg::STATUS_ADDR) ? statusWord : 32'h00000000;

    // Register slave: writes land in the data phase; read data is registered for the data phase.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wrPend_q <= 1'b0;
            wrAddr_q <= '0;
            rdData_q <= 32'h00000000;
            ctrl_q   <= aeqc_pkg::aeqc_ctrl_type'(aeqc_pkg::CTL_RESET[6:0]);
            limit_q  <= aeqc_pkg::LIMIT_RESET;
        end
        else
        begin
            wrPend_q <= addrPhase && hwrite;
            wrAddr_q <= busAddr;
            rdData_q <= (addrPhase && !hwrite) ? readMux : 32'h00000000;
            if (wrCtl)
            begin
                ctrl_q <= aeqc_pkg::aeqc_ctrl_type'(hwdata[6:0]);
            end
            if (wrLimit)
            begin
                limit_q <= hwdata[7:0];
            end
        end
    end

    // Timer terminals derived from the relock period.
    wire [aeqc_pkg::PERIOD_W-1:0] halfTerm = termOf({1'b0, relockPeriod[aeqc_pkg::PERIOD_W-1:1]});
    wire [aeqc_pkg::PERIOD_W-1:0] fullTerm = termOf(relockPeriod);
    wire                          halfEnd  = (timer_q == halfTerm);
    wire                          fullEnd  = (timer_q == fullTerm);

    // Error qualification by the select field.
    wire [2:0]                    errHits  = ctrl_q.errSel & errS2_q;
    wire                          anyErr   = |errHits;
    wire [aeqc_pkg::EQ_W+aeqc_pkg::FILT_W-1:0] advance =
        nextSetting(eq_q, filt_q, ctrl_q.filtEn, ctrl_q.loopOrder);
    wire [aeqc_pkg::CNT_W:0]      cntNow   = {1'b0, errCnt_q} + {{aeqc_pkg::CNT_W{1'b0}}, anyErr};
    wire                          cntOver  = (cntNow > {2'b00, limit_q});
    wire                          eqAtTop  = (eq_q == aeqc_pkg::EQ_MAX);

    // Adaptation sequencer.
    always_comb
    begin
        state_d  = state_q;
        timer_d  = timer_q + 1'b1;
        errCnt_d = errCnt_q;
        eq_d     = eq_q;
        filt_d   = filt_q;
        locked_d = locked_q;
        case (state_q)
            aeqc_pkg::ST_TRY:
            begin
                if (ctrl_q.twoStep && halfEnd)
                begin
                    state_d = aeqc_pkg::ST_VERIFY;
                    timer_d = '0;
                end
                else if (!ctrl_q.twoStep && fullEnd)
                begin
                    timer_d = '0;
                    if (lockS2_q)
                    begin
                        state_d  = aeqc_pkg::ST_TRACK;
                        locked_d = 1'b1;
                        errCnt_d = '0;
                    end
                    else
                    begin
                        {eq_d, filt_d} = advance;
                    end
                end
            end
            aeqc_pkg::ST_VERIFY:
            begin
                if (anyErr || !lockS2_q)
                begin
                    {eq_d, filt_d} = advance;
                    state_d = aeqc_pkg::ST_TRY;
                    timer_d = '0;
                end
                else if (halfEnd)
                begin
                    state_d  = aeqc_pkg::ST_TRACK;
                    locked_d = 1'b1;
                    errCnt_d = '0;
                    timer_d  = '0;
                end
            end
            aeqc_pkg::ST_TRACK:
            begin
                if (anyErr && errCnt_q != '1)
                begin
                    errCnt_d = errCnt_q + 1'b1;
                end
                if (!lockS2_q)
                begin
                    state_d  = aeqc_pkg::ST_TRY;
                    locked_d = 1'b0;
                    timer_d  = '0;
                end
                else if (halfEnd)
                begin
                    timer_d  = '0;
                    errCnt_d = '0;
                    if (cntOver && !eqAtTop)
                    begin
                        eq_d     = eq_q + 1'b1;
                        state_d  = aeqc_pkg::ST_TRY;
                        locked_d = 1'b0;
                    end
                end
            end
            default:
            begin
                state_d  = aeqc_pkg::ST_TRY;
                timer_d  = '0;
                locked_d = 1'b0;
            end
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q  <= aeqc_pkg::ST_TRY;
            timer_q  <= '0;
            errCnt_q <= '0;
            eq_q     <= '0;
            filt_q   <= '0;
            locked_q <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            timer_q  <= timer_d;
            errCnt_q <= errCnt_d;
            eq_q     <= eq_d;
            filt_q   <= filt_d;
            locked_q <= locked_d;
        end
    end

    // Data and setting outputs straight from flip-flops; the slave always answers OKAY with no wait state.
    assign hreadyout     = 1'b1;
    assign hresp         = 1'b0;
    assign hrdata        = rdData_q;
    assign eqSetting     = eq_q;
    assign filterSetting = filt_q;
    assign adaptLocked   = locked_q;

    // Checks of the documented behaviour.
    err_mask_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == aeqc_pkg::ST_TRACK && ctrl_q.errSel == 3'h0 && lockS2_q && !halfEnd) |=> $stable(errCnt_q))
        else $error("Errors counted while checking is disabled.");

    half_count_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == aeqc_pkg::ST_TRACK && lockS2_q && halfEnd) |=> errCnt_q == '0 && timer_q == '0)
        else $error("Error window did not close at the half period.");

    step_up_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == aeqc_pkg::ST_TRACK && lockS2_q && halfEnd && cntOver && !eqAtTop)
        |=> eq_q == $past(eq_q) + 1'b1 && state_q == aeqc_pkg::ST_TRY)
        else $error("Equalizer did not step up above the limit.");

    no_step_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == aeqc_pkg::ST_TRACK && lockS2_q && halfEnd && !cntOver) |=> $stable(eq_q))
        else $error("Equalizer stepped at or below the limit.");

    full_wait_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == aeqc_pkg::ST_TRY && !ctrl_q.twoStep && fullEnd && lockS2_q)
        |=> state_q == aeqc_pkg::ST_TRACK && locked_q)
        else $error("Locked setting not accepted after the full period.");

    two_step_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == aeqc_pkg::ST_TRY && ctrl_q.twoStep && halfEnd) |=> state_q == aeqc_pkg::ST_VERIFY)
        else $error("Second step not entered at the half period.");

    abort_step_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == aeqc_pkg::ST_VERIFY && anyErr)
        |=> state_q == aeqc_pkg::ST_TRY && {eq_q, filt_q} == $past(advance))
        else $error("Error in second step did not advance the setting.");

    loop_order_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == aeqc_pkg::ST_VERIFY && anyErr && ctrl_q.filtEn && ctrl_q.loopOrder
         && filt_q != aeqc_pkg::FILT_MAX) |=> $stable(eq_q) && filt_q == $past(filt_q) + 1'b1)
        else $error("Filter was not the inner loop.");

    reset_vals_a: assert property (@(posedge clk)
        rst |=> limit_q == aeqc_pkg::LIMIT_RESET && ctrl_q.filtEn)
        else $error("Limit or filter enable reset value wrong.");

    // Further checks of the sequencer transitions and of the register writes.
    err_count_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == aeqc_pkg::ST_TRACK && lockS2_q && !halfEnd && anyErr && errCnt_q != '1)
        |=> errCnt_q == $past(errCnt_q) + 1'b1)
        else $error("Enabled error was not counted.");

    full_retry_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == aeqc_pkg::ST_TRY && !ctrl_q.twoStep && fullEnd && !lockS2_q)
        |=> state_q == aeqc_pkg::ST_TRY && {eq_q, filt_q} == $past(advance))
        else $error("Unlocked setting was not replaced after the full period.");

    lock_drop_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == aeqc_pkg::ST_TRACK && !lockS2_q)
        |=> state_q == aeqc_pkg::ST_TRY && !locked_q && $stable(eq_q) && $stable(filt_q))
        else $error("Lock loss did not restart adaptation at the same setting.");

    verify_pass_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == aeqc_pkg::ST_VERIFY && !anyErr && lockS2_q && halfEnd)
        |=> state_q == aeqc_pkg::ST_TRACK && locked_q)
        else $error("Clean second step did not accept the setting.");

    ctl_write_a: assert property (@(posedge clk) disable iff (rst)
        wrCtl
        |=> {25'h0, ctrl_q} == ($past(hwdata) & 32'h0000007f))
        else $error("Control write did not land.");

    limit_write_a: assert property (@(posedge clk) disable iff (rst)
        wrLimit
        |=> {24'h000000, limit_q} == ($past(hwdata) & 32'h000000ff))
        else $error("Limit write did not land.");

endmodule

/* File: bench/aeqc_rx_model.sv */
// Receiver front-end model that feeds lock and error levels to the controller.
`timescale 1ns/1ps
module aeqc_rx_model
(
    input  wire logic             clk,
    input  wire logic             slowMode,
    input  wire logic             lockCmd,
    input  wire logic [2:0]       errCmd,
    output logic                  rxLock,
    output aeqc_pkg::aeqc_err_type rxErr
);
    logic [3:0] stage1Q = 4'h0;
    logic [3:0] stage2Q = 4'h0;

    // The commanded levels appear after one cycle, or two when the link answers slowly.
    always @(posedge clk)
    begin
        stage1Q <= {lockCmd, errCmd};
        stage2Q <= stage1Q;
    end

    // Error bits keep the select field order: clock pattern, control sequence, parity.
    assign {rxLock, rxErr} = slowMode ? stage2Q : stage1Q;
endmodule

/* File: bench/adaptive_eq_controller_tb.sv */
// Self-checking testbench of the adaptive equalizer controller.
`timescale 1ns/1ps
module adaptive_eq_controller_tb;
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   hsel = 1'b0;
    logic [31:0]            haddr = 32'h0;
    logic [1:0]             htrans = 2'h0;
    logic                   hwrite = 1'b0;
    logic [2:0]             hsize = 3'h2;
    logic [31:0]            hwdata = 32'h0;
    logic                   hreadyout;
    logic [31:0]            hrdata;
    logic                   hresp;
    logic                   rxLock;
    aeqc_pkg::aeqc_err_type rxErr;
    logic [15:0]            relockPeriod = 16'h0010;
    logic [3:0]             eqSetting;
    logic [2:0]             filterSetting;
    logic                   adaptLocked;
    logic                   slowMode = 1'b0;
    logic                   lockCmd = 1'b1;
    logic [2:0]             errCmd = 3'h0;
    logic [31:0]            seed = 32'h4a7dc127;
    logic [31:0]            rdVal;
    int                     fails = 0;
    int                     testsRun = 0;
    int                     p, c, eqM, fM;
    logic [7:0]             cfg, sel;

    // Free-running 250 MHz clock.
    always #2 clk = ~clk;

    aeqc_adaptive_eq_controller dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .rxLock(rxLock), .rxErr(rxErr), .relockPeriod(relockPeriod),
        .eqSetting(eqSetting), .filterSetting(filterSetting), .adaptLocked(adaptLocked));

    aeqc_rx_model rx_u (.clk(clk), .slowMode(slowMode), .lockCmd(lockCmd), .errCmd(errCmd),
        .rxLock(rxLock), .rxErr(rxErr));

    // Advances the fixed-seed xorshift generator.
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Prints the verdict and ends the run.
    task automatic give_verdict;
        if (fails == 0 && testsRun > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Waits a bounded number of edges for the slave to signal ready.
    task automatic wait_ready;
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1)
        begin
            fails++;
            give_verdict();
        end
    endtask

    // One single-word transfer: address phase, then data phase.
    task automatic bus_xfer(input logic [11:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus_xfer(a, 1'b1, d, r);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus_xfer(a, 1'b0, 32'h0, r);
        chk(r, exp);
    endtask

    // Waits a bounded time for the setting to be accepted.
    task automatic wait_lock;
        int n;
        n = 0;
        while (adaptLocked !== 1'b1 && n < 300)
        begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, adaptLocked}, 32'h1);
    endtask

    // Counts edges until the equalizer or filter setting moves.
    task automatic wait_change(output int cnt);
        logic [6:0] prev;
        prev = {filterSetting, eqSetting};
        cnt = 0;
        while ({filterSetting, eqSetting} === prev && cnt < 400)
        begin
            @(posedge clk);
            cnt++;
        end
        if (cnt >= 400)
        begin
            fails++;
            give_verdict();
        end
    endtask

    // Resets with the link locked so tracking starts at setting zero, then programs the registers.
    task automatic restart(input logic [7:0] ctl, input logic [7:0] lim);
        lockCmd <= 1'b1;
        errCmd <= 3'h0;
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        wait_lock();
        wr(aeqc_pkg::CTL_ADDR, {24'h0, ctl});
        wr(aeqc_pkg::LIMIT_ADDR, {24'h0, lim});
    endtask

    // Main sequence.
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rdchk(aeqc_pkg::CTL_ADDR, 32'h1);
        rdchk(aeqc_pkg::LIMIT_ADDR, 32'h1);
        rdchk(12'h200, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        seed = xorshift(seed);
        wr(aeqc_pkg::LIMIT_ADDR, {24'h0, seed[7:0] | 8'h01});
        rdchk(aeqc_pkg::LIMIT_ADDR, {24'h0, seed[7:0] | 8'h01});
        wr(aeqc_pkg::CTL_ADDR, 32'hff);
        rdchk(aeqc_pkg::CTL_ADDR, 32'h7f);
        // Scan without validation: filter off, equalizer inner, filter inner.
        for (int i = 0; i < 3; i++)
        begin
            cfg = (i == 0) ? 8'h00 : ((i == 1) ? 8'h01 : 8'h03);
            seed = xorshift(seed);
            p = 12 + int'(seed[2:0]);
            relockPeriod <= 16'(p);
            slowMode <= seed[3];
            restart(cfg, 8'h01);
            lockCmd <= 1'b0;
            eqM = 0;
            fM = 0;
            for (int k = 0; k < 20; k++)
            begin
                wait_change(c);
                if (!cfg[0])
                    eqM = (eqM + 1) % 16;
                else if (!cfg[1])
                begin
                    eqM = (eqM + 1) % 16;
                    fM = (eqM == 0) ? (fM + 1) % 8 : fM;
                end
                else
                begin
                    fM = (fM + 1) % 8;
                    eqM = (fM == 0) ? (eqM + 1) % 16 : eqM;
                end
                chk(32'({filterSetting, eqSetting}), 32'(fM * 16 + eqM));
                if (k > 0)
                    chk(32'(c >= p && c <= p + 3), 32'h1);
            end
        end
        // Two-step validation with each error type, then with checking off.
        p = 16;
        relockPeriod <= 16'h0010;
        slowMode <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            sel = (i < 3) ? (8'h01 << i) : 8'h00;
            restart({1'b0, sel[2:0], 4'h7}, 8'hff);
            errCmd <= (i < 3) ? sel[2:0] : 3'h7;
            lockCmd <= 1'b0;
            repeat (3) @(posedge clk);
            lockCmd <= 1'b1;
            if (i < 3)
            begin
                wait_change(c);
                wait_change(c);
                chk(32'(c >= p / 2 && c <= p / 2 + 3), 32'h1);
                chk(32'({filterSetting, eqSetting}), 32'h20);
                errCmd <= 3'h0;
                wait_lock();
            end
            else
            begin
                repeat (3 * p) @(posedge clk);
                chk({31'h0, adaptLocked}, 32'h1);
                chk({28'h0, eqSetting}, 32'h0);
                rdchk(aeqc_pkg::STATUS_ADDR, (32'h2 << aeqc_pkg::ST_STATE_LSB) | (32'h1 << aeqc_pkg::ST_LOCK_BIT));
            end
        end
        // Tracking: a count at or under the limit holds, above it steps up.
        restart(8'h70, 8'd10);
        errCmd <= 3'h1;
        repeat (3 * p) @(posedge clk);
        chk({28'h0, eqSetting}, 32'h0);
        chk({31'h0, adaptLocked}, 32'h1);
        restart(8'h70, 8'd5);
        errCmd <= 3'h2;
        wait_change(c);
        chk({28'h0, eqSetting}, 32'h1);
        chk(32'(c <= p + 4), 32'h1);
        rdchk(aeqc_pkg::STATUS_ADDR, 32'h1 << aeqc_pkg::ST_EQ_LSB);
        give_verdict();
    end
endmodule
